// ---- inc/ptq_pkg.sv ----
// types of the transmit stream byte qualifier
package ptq_pkg;
    typedef enum logic [1:0] {
        PTQ_IDLE = 2'b00,
        PTQ_BODY = 2'b01
    } ptq_state_t;
endpackage : ptq_pkg

// ---- inc/ptq_regs.svh ----
// constants of the transmit stream byte qualifier
`ifndef PTQ_REGS_SVH
`define PTQ_REGS_SVH
`define PTQ_DATA_W_DEF   64
`define PTQ_FIFO_DEPTH   4
`define PTQ_KEEP_ALL64   8'hFF
`define PTQ_KEEP_LOW64   8'h0F
`define PTQ_KEEP_ALL128  16'hFFFF
`define PTQ_KEEP_Q1_128  16'h000F
`define PTQ_KEEP_Q2_128  16'h00FF
`define PTQ_KEEP_Q3_128  16'h0FFF
`endif

// ---- tb/ptq_app_model.sv ----
// application side that sources packet beats
`timescale 1ns/1ps
module ptq_app (
    input  wire logic   clk_i,
    input  wire logic   rdy_i,
    output logic [63:0] d_o,
    output logic [7:0]  k_o,
    output logic        l_o,
    output logic        v_o
);
    initial {v_o, l_o, k_o, d_o} = '0;
    // caller picks keep per beat position
    task automatic send(logic [63:0] d, logic [7:0] k, logic l);
        logic acc;
        @(posedge clk_i);
        #1 {v_o, l_o, k_o, d_o} = {1'b1, l, k, d};
        // ready is read mid-cycle where it is settled; the next edge then takes the beat
        do
        begin
            @(negedge clk_i);
            acc = rdy_i;
            @(posedge clk_i);
        end
        while (!acc);
        // released lines show garbage, not the old beat
        #1 {v_o, l_o, k_o, d_o} = {1'b0, ~l, ~k, ~d};
    endtask : send
endmodule : ptq_app

// ---- tb/ptq_tx_stream_assertions.sv ----
// port assertions of the transmit stream input
`timescale 1ns/1ps
module ptq_chk #(parameter int DATA_W = 64) (
    input wire logic                clk_i,
    input wire logic                rst_i,
    input wire logic                ce_i,
    input wire logic                tx_valid_o,
    input wire logic                tx_ready_i,
    input wire logic                keep_err_o,
    input wire logic                s_axis_tx_tvalid,
    input wire logic                s_axis_tx_tready,
    input wire logic                s_axis_tx_tlast,
    input wire logic [DATA_W/8-1:0] s_axis_tx_tkeep,
    input wire logic [DATA_W/8-1:0] tx_keep_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // one beat moves on each edge with both sides high
    wire acc = s_axis_tx_tvalid && s_axis_tx_tready;
    AST_CE: assert property (!ce_i |-> !s_axis_tx_tready)
        else $error("ready while frozen");
    AST_TAKE: assert property (acc |=> tx_valid_o)
        else $error("beat lost");
    AST_HOLD: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_keep_o))
        else $error("head moved");
    AST_MID: assert property (acc && !s_axis_tx_tlast && !(&s_axis_tx_tkeep) |=> keep_err_o)
        else $error("short mid keep missed");
    AST_LAST: assert property (acc && s_axis_tx_tlast && !keep_err_o
        && s_axis_tx_tkeep inside {'hF, 'hFF, 'hFFF, 'hFFFF} |=> !keep_err_o)
        else $error("legal keep flagged");
    AST_STICK: assert property (keep_err_o |=> keep_err_o)
        else $error("error flag dropped");
    C_ACC: cover property (acc);
    C_FULL: cover property (ce_i && !s_axis_tx_tready);
    C_ERR: cover property ($rose(keep_err_o));
endmodule : ptq_chk
bind ptq_tx_stream ptq_chk #(.DATA_W(DATA_W)) chk_u (.clk_i, .rst_i, .ce_i, .tx_valid_o,
    .tx_ready_i, .keep_err_o, .s_axis_tx_tvalid, .s_axis_tx_tready, .s_axis_tx_tlast,
    .s_axis_tx_tkeep, .tx_keep_o);

// ---- tb/tb.sv ----
// bench for the transmit stream input
`timescale 1ns/1ps
module tb;
    logic        clk_i = 0, rst_i = 1, ce_i = 1, tx_ready_i = 0;
    logic [63:0] d, tx_data_o;
    logic [7:0]  k, tx_keep_o;
    logic        l, v, rdy, tx_last_o, tx_valid_o, keep_err_o, pk;
    int          failures = 0, n_checks = 0;
    initial forever #25 clk_i = ~clk_i;
    ptq_app app_u (.clk_i, .rdy_i(rdy), .d_o(d), .k_o(k), .l_o(l), .v_o(v));
    ptq_tx_stream dut_u (.clk_i, .rst_i, .ce_i, .s_axis_tx_tdata(d), .s_axis_tx_tkeep(k),
        .s_axis_tx_tlast(l), .s_axis_tx_tvalid(v), .s_axis_tx_tready(rdy), .tx_data_o,
        .tx_keep_o, .tx_last_o, .tx_valid_o, .tx_ready_i, .keep_err_o, .in_packet_o(pk));
    task automatic chk(logic [63:0] g, e);
        n_checks++;
        if (g !== e)
        begin
            failures++;
            $display("BAD %0t %h %h", $time, g, e);
        end
    endtask : chk
    task automatic complete_run;
        if (failures == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run
    // four beats with the sink stalled, then drain in order
    task automatic t_fill;
        for (int i = 0; i < 4; i++)
            app_u.send(64'hA0 + i, i == 3 ? 8'h0F : 8'hFF, i == 3);
        @(negedge clk_i) chk(rdy, 0);
        chk(pk, 0);
        @(posedge clk_i) #1 tx_ready_i = 1;
        for (int i = 0; i < 4; i++)
        begin
            @(negedge clk_i) chk(tx_data_o, 64'hA0 + i);
            chk(tx_keep_o, i == 3 ? 8'h0F : 8'hFF);
            chk(tx_last_o, i == 3);
        end
        @(negedge clk_i) chk(tx_valid_o, 0);
        chk(keep_err_o, 0);
    endtask : t_fill
    // frozen core must refuse
    task automatic t_ce;
        @(posedge clk_i) #1 ce_i = 0;
        @(negedge clk_i) chk(rdy, 0);
        @(posedge clk_i) #1 ce_i = 1;
        @(negedge clk_i) chk(rdy, 1);
    endtask : t_ce
    // short keep in mid packet is flagged
    task automatic t_err;
        app_u.send(64'h5, 8'h0F, 0);
        @(negedge clk_i) chk(keep_err_o, 1);
        chk(pk, 1);
    endtask : t_err
    initial
    begin
        repeat (2) @(posedge clk_i);
        #1 rst_i = 0;
        t_fill;
        t_ce;
        t_err;
        complete_run;
    end
    initial
    begin
        #100000;
        failures++;
        complete_run;
    end
endmodule : tb

// ---- verilog/ptq_fifo.sv ----
// holds no logic: the word buffer module sits beside the stream input that uses it

// ---- verilog/ptq_tx_stream.sv ----
// transmit stream input with byte qualifier check and buffering
// How it works
// - data path is built 64 or 128 bits wide, chosen by parameter.
// - keep input has one bit per data byte, 8 or 16 bits.
// - keep bit 0 qualifies lowest byte, top bit the highest byte.
// - ready is high only when a beat can be taken this cycle.
// - a beat moves exactly when valid and ready are both high.
`timescale 1ns/1ps
`include "ptq_regs.svh"
module ptq_tx_stream #(
    parameter int DATA_W = `PTQ_DATA_W_DEF,
    parameter int DEPTH  = `PTQ_FIFO_DEPTH
) (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                ce_i,
    input  wire logic [DATA_W-1:0]   s_axis_tx_tdata,
    input  wire logic [DATA_W/8-1:0] s_axis_tx_tkeep,
    input  wire logic                s_axis_tx_tlast,
    input  wire logic                s_axis_tx_tvalid,
    output logic                     s_axis_tx_tready,
    output logic [DATA_W-1:0]        tx_data_o,
    output logic [DATA_W/8-1:0]      tx_keep_o,
    output logic                     tx_last_o,
    output logic                     tx_valid_o,
    input  wire logic                tx_ready_i,
    output logic                     keep_err_o,
    output logic                     in_packet_o
);
    import ptq_pkg::*;

    // derived widths of the keep field and of one buffered word
    // keep and last ride above the data so one slice unpacks each field
    localparam int KW       = DATA_W / 8;
    localparam int FW       = DATA_W + KW + 1;
    localparam int KEEP_LSB = DATA_W;        // keep sits just above the data
    localparam int LAST_BIT = FW - 1;        // last is the top bit of the word

    // only the two built widths are served; a third would break the keep tables
    if (DATA_W != 64 && DATA_W != 128)
    begin : g_bad_width
        $error("data width must be 64 or 128");
    end

    // the buffer indexes by wrapping pointers, so its depth must be a power of two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("fifo depth must be a power of two of at least 2");
    end

    // every lane qualified; the only shape allowed before the last beat
    function automatic logic keep_full(input logic [KW-1:0] k);
        logic ok;
        ok = (k == {KW{1'b1}});
        return ok;
    endfunction : keep_full

    // whole groups of four bytes filled from lane 0 upward; bit 0 is the lowest byte
    function automatic logic keep_tail(input logic [KW-1:0] k);
        logic ok;
        ok = 1'b0;
        if (KW == 8)
        begin
            ok = (k == KW'(`PTQ_KEEP_LOW64))
              || (k == KW'(`PTQ_KEEP_ALL64));
        end
        else
        begin
            ok = (k == KW'(`PTQ_KEEP_Q1_128))
              || (k == KW'(`PTQ_KEEP_Q2_128))
              || (k == KW'(`PTQ_KEEP_Q3_128))
              || (k == KW'(`PTQ_KEEP_ALL128));
        end
        return ok;
    endfunction : keep_tail

    // legal keep for a beat, depending on whether it closes the packet
    function automatic logic keep_ok(input logic [KW-1:0] k, input logic last);
        logic ok;
        if (last)
            ok = keep_tail(k);
        else
            ok = keep_full(k);
        return ok;
    endfunction : keep_ok

    // illegal keeps are still forwarded; only the flag records them, nothing is dropped
    logic             fifo_in_ready;   // room for one more word
    logic             take;            // a beat moves on this edge
    logic [FW-1:0]    fifo_in;         // word written into the buffer
    logic [FW-1:0]    fifo_out;        // word at the head of the buffer
    logic             beat_bad;        // accepted beat breaks the keep rules
    ptq_state_t       state_q;
    ptq_state_t       state_d;
    logic             err_q;
    logic             err_d;

    // ready reflects free room this very cycle; the enable forces it low so that
    // no beat can be taken while the state is frozen
    assign s_axis_tx_tready = fifo_in_ready & ce_i;

    // a transfer needs both sides high on the same edge
    assign take = s_axis_tx_tvalid & s_axis_tx_tready;

    // data, keep and last are packed as one word so they can never drift apart
    assign fifo_in = {s_axis_tx_tlast, s_axis_tx_tkeep, s_axis_tx_tdata};

    // small buffer between the application and the link side
    ptq_fifo #(
        .WIDTH (FW),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .in_data_i   (fifo_in),
        .in_valid_i  (s_axis_tx_tvalid),
        .in_ready_o  (fifo_in_ready),
        .out_data_o  (fifo_out),
        .out_valid_o (tx_valid_o),
        .out_ready_i (tx_ready_i)
    );

    // keep travels with its bytes unchanged, so lane order is preserved
    assign tx_data_o = fifo_out[DATA_W-1:0];
    assign tx_keep_o = fifo_out[KEEP_LSB +: KW];
    assign tx_last_o = fifo_out[LAST_BIT];

    // packet tracking; a last beat closes the packet, any other opens or continues it
    // the two spare codes fall back to idle rather than lock up
    always_comb
    begin
        state_d = state_q;
        if (take)
        begin
            unique case (state_q)
                PTQ_IDLE:
                begin
                    state_d = s_axis_tx_tlast ? PTQ_IDLE : PTQ_BODY;
                end
                PTQ_BODY:
                begin
                    state_d = s_axis_tx_tlast ? PTQ_IDLE : PTQ_BODY;
                end
                default:
                begin
                    state_d = PTQ_IDLE;
                end
            endcase
        end
    end

    // packet state register; the enable freezes it
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state_q <= PTQ_IDLE;
        else if (ce_i)
            state_q <= state_d;
    end

    // judge only beats that really move; an idle bus may carry anything
    // a beat refused by ready is judged only when it is finally taken
    assign beat_bad = take & ~keep_ok(s_axis_tx_tkeep, s_axis_tx_tlast);

    // sticky: once set it stays until reset, so a slow reader cannot miss it
    assign err_d = err_q | beat_bad;

    // error register; frozen with the rest of the block
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            err_q <= 1'b0;
        else if (ce_i)
            err_q <= err_d;
    end

    // error status straight from its register
    assign keep_err_o  = err_q;

    // inside a packet while the last accepted beat was not a last one
    assign in_packet_o = (state_q == PTQ_BODY);
endmodule : ptq_tx_stream

// small synchronous fifo with valid/ready on both sides
module ptq_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic [WIDTH-1:0]      out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    // pointer width; the count needs one bit more to tell full from empty
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // wrapping pointers need a power of two depth
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("fifo depth must be a power of two of at least 2");
    end

    // storage, pointers and fill count
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    // honest full and empty from the fill count; moves are frozen with the enable
    assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem_q[rd_q];
    assign push        = ce_i & in_valid_i & in_ready_o;
    assign pop         = ce_i & out_valid_o & out_ready_i;

    // storage array, no reset needed on data since the count guards it
    always_ff @(posedge clk_i)
    begin
        if (push)
            mem_q[wr_q] <= in_data_i;
    end

    // pointers and count; the count moves only when exactly one side moves
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= wr_q + 1'b1;
            if (pop)
                rd_q <= rd_q + 1'b1;
            if (push && !pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop && !push)
                cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule : ptq_fifo
